// File: curve_rom.sv
/*
 * Constant table of the eleven inverse curves, read data registered.
 * Assumes a synchronous active-low reset and an address that is held.
 */
module curve_rom (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic [3:0]      addr,
    output neg_seq_pkg::curve_t  data
);

    neg_seq_pkg::rom_state_t st_reg;
    neg_seq_pkg::rom_state_t st_next;

    // =================================================================
    // Table: k, c and kr in units of 100 us
    always_comb begin
        st_next = st_reg;
        unique case (addr)
            4'h0: st_next.data = {21'h000578, 13'h0000, 19'h00000, neg_seq_pkg::ALPHA_002, 1'b1};
            4'h1: st_next.data = {21'h020F58, 13'h0000, 19'h00000, neg_seq_pkg::ALPHA_1,   1'b1};
            4'h2: st_next.data = {21'h0C3500, 13'h0000, 19'h00000, neg_seq_pkg::ALPHA_2,   1'b1};
            4'h3: st_next.data = {21'h124F80, 13'h0000, 19'h00000, neg_seq_pkg::ALPHA_1,   1'b1};
            4'h4: st_next.data = {21'h000056, 13'h00B9, 19'h011F8, neg_seq_pkg::ALPHA_002, 1'b0};
            4'h5: st_next.data = {21'h000203, 13'h0474, 19'h0BD74, neg_seq_pkg::ALPHA_002, 1'b0};
            4'h6: st_next.data = {21'h02FE04, 13'h132E, 19'h34BC0, neg_seq_pkg::ALPHA_2,   1'b0};
            4'h7: st_next.data = {21'h044D90, 13'h04C1, 19'h470B8, neg_seq_pkg::ALPHA_2,   1'b0};
            4'h8: st_next.data = {21'h00035C, 13'h073A, 19'h0B3B0, neg_seq_pkg::ALPHA_002, 1'b0};
            4'h9: st_next.data = {21'h045B3C, 13'h1BD0, 19'h20DC8, neg_seq_pkg::ALPHA_2,   1'b0};
            4'hA: st_next.data = {21'h09C6BC, 13'h09C4, 19'h493E0, neg_seq_pkg::ALPHA_2,   1'b0};
            default: st_next.data = '0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign data = st_reg.data;

endmodule

// File: neg_seq_defines.svh
/*
 * Constants of the negative sequence overcurrent element: clock and time
 * base, operating modes, fixed-point scalings of the curve arithmetic.
 * Assumes inclusion by bare name from the package users.
 */
`ifndef NEG_SEQ_DEFINES_SVH
`define NEG_SEQ_DEFINES_SVH

// =====================================================================
// Timing
`define CLK_PERIOD_NS    20
`define TICK_NS          1000000

// =====================================================================
// Operating mode codes
`define MODE_OFF         4'h0
`define MODE_DEFINITE    4'h1
`define MODE_FIRST_CURVE 4'h2
`define MODE_LAST_CURVE  4'hC

// =====================================================================
// Fixed-point figures
`define CEIL_RATIO       21'h14
`define CEIL_RATIO_Q8    13'h1400
`define UNITY_Q8         13'h100
`define ONE_Q16          26'h10000
`define GUARANTEE_Q8     13'h11A
`define E4_PER_MS        52'hA
`define C_SCALE          40'hA00
`define LN2_Q8           19'hB1
`define ALPHA002_Q8      20'h51F
`define DIV_STEPS        5'h18

`endif

// File: neg_seq_overcurrent_element.sv
/*
 * Start and delayed trip of the negative sequence overcurrent element,
 * definite time or one of eleven inverse curves, integrated on a 1 ms tick.
 * Assumes the magnitude and its valid strobe come from logic on sys_clk and
 * that settings are held steady while the element runs.
 */
`include "neg_seq_defines.svh"

module neg_seq_overcurrent_element #(
    parameter int unsigned TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   meas_valid,
    input  wire logic [15:0]            neg_seq_fundamental_magnitude,
    input  wire neg_seq_pkg::settings_t settings,
    output logic                        start_out,
    output logic                        trip_out
);

    neg_seq_pkg::elem_state_t st_reg;
    neg_seq_pkg::elem_state_t st_next;
    neg_seq_pkg::curve_t      cv;
    logic [3:0]               rom_addr;
    logic                     is_def;
    logic                     is_inv;
    logic                     active;
    logic                     fixed_rst;
    logic                     tick;
    logic [25:0]              den;
    logic [25:0]              rden;
    logic                     acc_done;
    logic                     c_done;
    logic                     r_done;

    // =================================================================
    // Curve arithmetic
    function automatic logic [10:0] log2_q8(input logic [12:0] r);
        logic [12:0] sh;
        int          p;
        p = 8;
        for (int i = 8; i < 13; i++) begin
            if (r[i]) begin
                p = i;
            end
        end
        sh = r << (12 - p);
        // Linear mantissa: exact at powers of two, below the true log between them
        return {3'(p - 8), sh[11:4]};
    endfunction

    function automatic logic [25:0] den_fn(input neg_seq_pkg::alpha_t a, input logic [12:0] r);
        logic [25:0] sq;
        logic [18:0] ln_q8;
        logic [19:0] x;
        sq = 26'(r) * 26'(r);
        ln_q8 = 19'((19'(log2_q8(r)) * `LN2_Q8) >> 8);
        x = 20'((20'(ln_q8) * `ALPHA002_Q8) >> 8);
        if (r <= `UNITY_Q8) begin
            return 26'h0000000;
        end
        unique case (a)
            neg_seq_pkg::ALPHA_1:   return {5'h00, r - `UNITY_Q8, 8'h00};
            neg_seq_pkg::ALPHA_2:   return sq - `ONE_Q16;
            // Second-order series of exp keeps the 0,02 power accurate
            neg_seq_pkg::ALPHA_002: return 26'(x) + 26'((40'(x) * 40'(x)) >> 17);
            default:                return 26'h0000000;
        endcase
    endfunction

    // =================================================================
    // Mode decode and curve table
    assign rom_addr  = settings.mode - `MODE_FIRST_CURVE;
    assign is_def    = (settings.mode == `MODE_DEFINITE);
    assign is_inv    = (settings.mode >= `MODE_FIRST_CURVE) && (settings.mode <= `MODE_LAST_CURVE);
    assign active    = is_def || is_inv;
    assign fixed_rst = is_def || cv.fixed_reset;
    assign tick      = (st_reg.tick_cnt == 16'(TICK_CYCLES - 1));

    curve_rom u_curve_rom (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .addr    (rom_addr),
        .data    (cv)
    );

    assign den      = den_fn(cv.alpha, st_reg.ratio);
    assign rden     = (st_reg.ratio < `UNITY_Q8) ?
                      `ONE_Q16 - 26'(st_reg.ratio) * 26'(st_reg.ratio) : 26'h0000000;
    assign acc_done = 52'(st_reg.acc) * `E4_PER_MS >=
                      52'({37'(settings.tms_q8) * 37'(cv.k_e4), 8'h00});
    assign c_done   = 40'(st_reg.cphase) * `C_SCALE >= 40'(settings.tms_q8) * 40'(cv.c_e4);
    assign r_done   = 52'(st_reg.racc) * `E4_PER_MS >=
                      52'({35'(settings.tms_q8) * 35'(cv.kr_e4), 8'h00});

    // =================================================================
    // Next state
    always_comb begin
        logic [16:0] rem_s;
        rem_s = {st_reg.div_rem[15:0], st_reg.div_num[23]};
        st_next = st_reg;
        st_next.tick_cnt = tick ? 16'h0000 : st_reg.tick_cnt + 16'h0001;

        // Ratio to start setting, one quotient bit per cycle
        if (st_reg.div_busy) begin
            st_next.div_num = {st_reg.div_num[22:0], 1'b0};
            if (rem_s >= {1'b0, settings.start_current_setting}) begin
                st_next.div_rem = rem_s - {1'b0, settings.start_current_setting};
                st_next.div_quo = {st_reg.div_quo[22:0], 1'b1};
            end else begin
                st_next.div_rem = rem_s;
                st_next.div_quo = {st_reg.div_quo[22:0], 1'b0};
            end
            st_next.div_cnt = st_reg.div_cnt - 5'h01;
            if (st_reg.div_cnt == 5'h01) begin
                st_next.div_busy = 1'b0;
                st_next.ratio = (st_next.div_quo >= 24'(`CEIL_RATIO_Q8)) ?
                                `CEIL_RATIO_Q8 : st_next.div_quo[12:0];
            end
        end

        // A new sample restarts the divider, or stops it and loads the ceiling ratio at 20 times setting
        if (meas_valid) begin
            st_next.picked = active && (neg_seq_fundamental_magnitude > settings.start_current_setting);
            if (21'(neg_seq_fundamental_magnitude) >= 21'(settings.start_current_setting) * `CEIL_RATIO) begin
                st_next.above_ceil = 1'b1;
                st_next.ratio = `CEIL_RATIO_Q8;
                st_next.div_busy = 1'b0;
            end else begin
                st_next.above_ceil = 1'b0;
                st_next.div_busy = 1'b1;
                st_next.div_cnt = `DIV_STEPS;
                st_next.div_num = {neg_seq_fundamental_magnitude, 8'h00};
                st_next.div_rem = 17'h00000;
                st_next.div_quo = 24'h000000;
            end
        end

        if (tick && st_reg.picked) begin
            st_next.elapsed = (st_reg.elapsed == 24'hFFFFFF) ? st_reg.elapsed : st_reg.elapsed + 24'h000001;
            unique case (st_reg.phase)
                neg_seq_pkg::PH_IDLE, neg_seq_pkg::PH_HOLD: begin
                    st_next.phase = neg_seq_pkg::PH_RUN;
                    st_next.racc = 48'h000000000000;
                end
                neg_seq_pkg::PH_RUN: begin
                    if (is_def) begin
                        if (st_next.elapsed >= 24'(settings.definite_delay_ms)) begin
                            st_next.phase = neg_seq_pkg::PH_TRIP;
                        end
                    end else begin
                        // Beyond the ceiling the c share runs first, then the curve share
                        if (st_reg.above_ceil && !c_done) begin
                            st_next.cphase = st_reg.cphase + 24'h000001;
                        end else if (!acc_done) begin
                            st_next.acc = st_reg.acc + 48'(den);
                        end
                        if (acc_done && (c_done || !st_reg.above_ceil) &&
                            st_reg.elapsed >= 24'(settings.minimum_delay_setting)) begin
                            st_next.phase = neg_seq_pkg::PH_TRIP;
                        end
                    end
                end
                neg_seq_pkg::PH_TRIP: begin
                    st_next.phase = neg_seq_pkg::PH_TRIP;
                end
            endcase
        end else if (tick) begin
            unique case (st_reg.phase)
                neg_seq_pkg::PH_IDLE: begin
                    st_next.phase = neg_seq_pkg::PH_IDLE;
                end
                neg_seq_pkg::PH_RUN, neg_seq_pkg::PH_TRIP: begin
                    st_next.phase = neg_seq_pkg::PH_HOLD;
                end
                neg_seq_pkg::PH_HOLD: begin
                    // Timing memory survives a short dip until the reset time runs out
                    if (fixed_rst) begin
                        st_next.racc = st_reg.racc + 48'h000000000001;
                        if (st_next.racc >= 48'(settings.reset_delay_setting)) begin
                            st_next.phase = neg_seq_pkg::PH_IDLE;
                        end
                    end else if (r_done) begin
                        st_next.phase = neg_seq_pkg::PH_IDLE;
                    end else begin
                        st_next.racc = st_reg.racc + 48'(rden);
                    end
                    if (st_next.phase == neg_seq_pkg::PH_IDLE) begin
                        st_next.acc = 48'h000000000000;
                        st_next.cphase = 24'h000000;
                        st_next.elapsed = 24'h000000;
                        st_next.racc = 48'h000000000000;
                    end
                end
            endcase
        end

        if (!active) begin
            st_next.phase = neg_seq_pkg::PH_IDLE;
            st_next.picked = 1'b0;
            st_next.acc = 48'h000000000000;
            st_next.racc = 48'h000000000000;
            st_next.cphase = 24'h000000;
            st_next.elapsed = 24'h000000;
        end
        st_next.start = st_next.picked;
        st_next.trip = st_next.picked && (st_next.phase == neg_seq_pkg::PH_TRIP);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign start_out = st_reg.start;
    assign trip_out  = st_reg.trip;

    // =================================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    pickup_gate_a: assert property (meas_valid && neg_seq_fundamental_magnitude <= settings.start_current_setting
        |=> !st_reg.start) else $error("start raised at or below setting");
    start_source_a: assert property ($rose(st_reg.start) |-> $past(meas_valid))
        else $error("start rose without a measurement");
    off_quiet_a: assert property (!active |=> !st_reg.start && !st_reg.trip && st_reg.phase == neg_seq_pkg::PH_IDLE)
        else $error("element active while off");
    definite_delay_a: assert property ($rose(st_reg.trip) && is_def
        |-> st_reg.elapsed >= 24'(settings.definite_delay_ms)) else $error("definite trip too early");
    inverse_target_a: assert property ($rose(st_reg.trip) && is_inv |-> $past(acc_done))
        else $error("inverse trip before target");
    first_curve_a: assert property ($past(rom_addr) == 4'h0 && $stable(rom_addr)
        |-> cv.k_e4 == 21'h000578 && cv.alpha == neg_seq_pkg::ALPHA_002 && cv.c_e4 == 13'h0000)
        else $error("first curve constants wrong");
    ratio_ceiling_a: assert property (st_reg.ratio <= `CEIL_RATIO_Q8 &&
        (st_reg.above_ceil -> st_reg.ratio == `CEIL_RATIO_Q8)) else $error("ratio above ceiling");
    c_share_first_a: assert property (is_inv && tick && st_reg.picked && st_reg.phase == neg_seq_pkg::PH_RUN
        && st_reg.above_ceil && !c_done |=> st_reg.acc == $past(st_reg.acc)) else $error("curve share before c");
    guarantee_den_a: assert property (is_inv && st_reg.ratio >= `GUARANTEE_Q8 |-> den != 26'h0000000)
        else $error("no progress above guarantee");
    fixed_reset_a: assert property (active && fixed_rst && tick && !st_reg.picked &&
        st_reg.phase == neg_seq_pkg::PH_HOLD && st_reg.racc + 48'h000000000001 >= 48'(settings.reset_delay_setting)
        |=> st_reg.phase == neg_seq_pkg::PH_IDLE && st_reg.acc == 48'h000000000000) else $error("fixed reset missed");
    ansi_reset_a: assert property (active && !fixed_rst && tick && !st_reg.picked && !r_done &&
        st_reg.phase == neg_seq_pkg::PH_HOLD |=> st_reg.phase == neg_seq_pkg::PH_HOLD &&
        st_reg.racc == $past(st_reg.racc) + 48'($past(rden))) else $error("ansi reset integration wrong");
    min_delay_a: assert property ($rose(st_reg.trip) && is_inv
        |-> $past(st_reg.elapsed) >= 24'(settings.minimum_delay_setting)) else $error("trip under minimum delay");

    definite_trip_c: cover property ($rose(st_reg.trip) && is_def);
    inverse_trip_c: cover property ($rose(st_reg.trip) && is_inv && !st_reg.above_ceil);
    ceiling_trip_c: cover property ($rose(st_reg.trip) && is_inv && st_reg.above_ceil);
    ansi_reset_c: cover property (st_reg.phase == neg_seq_pkg::PH_HOLD && !fixed_rst ##1 st_reg.phase == neg_seq_pkg::PH_IDLE);

endmodule

// File: neg_seq_pkg.sv
/*
 * Types of the negative sequence overcurrent element: phases, curve
 * constants, settings carrier and the packed state records.
 * Assumes nothing of its surroundings.
 */
package neg_seq_pkg;

    // =================================================================
    // Enumerations
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RUN  = 2'b01,
        PH_TRIP = 2'b10,
        PH_HOLD = 2'b11
    } phase_t;

    typedef enum logic [1:0] {
        ALPHA_002 = 2'b00,
        ALPHA_1   = 2'b01,
        ALPHA_2   = 2'b10
    } alpha_t;

    // =================================================================
    // Carriers
    typedef struct packed {
        logic [20:0] k_e4;
        logic [12:0] c_e4;
        logic [18:0] kr_e4;
        alpha_t      alpha;
        logic        fixed_reset;
    } curve_t;

    typedef struct packed {
        logic [3:0]  mode;
        logic [15:0] start_current_setting;
        logic [15:0] tms_q8;
        logic [15:0] definite_delay_ms;
        logic [15:0] minimum_delay_setting;
        logic [15:0] reset_delay_setting;
    } settings_t;

    typedef struct packed {
        phase_t      phase;
        logic [15:0] tick_cnt;
        logic        div_busy;
        logic [4:0]  div_cnt;
        logic [23:0] div_num;
        logic [16:0] div_rem;
        logic [23:0] div_quo;
        logic        picked;
        logic        above_ceil;
        logic [12:0] ratio;
        logic [47:0] acc;
        logic [47:0] racc;
        logic [23:0] elapsed;
        logic [23:0] cphase;
        logic        start;
        logic        trip;
    } elem_state_t;

    typedef struct packed {
        curve_t data;
    } rom_state_t;

endpackage

// File: testbench.sv
/*
 * Self-checking bench of the negative sequence overcurrent element.
 * Assumes a 1 us tick (TICK_CYCLES 50) so that setting "ms" map to 50 clocks.
 */
`include "neg_seq_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned TICK = 50;

    logic                   sys_clk;
    logic                   rst_n;
    logic                   meas_valid;
    logic [15:0]            magnitude;
    logic [15:0]            level;
    neg_seq_pkg::settings_t settings;
    logic                   start_out;
    logic                   trip_out;
    int                     bad_count;
    int                     n_checks;
    int                     ms;

    neg_seq_overcurrent_element #(.TICK_CYCLES(TICK)) i_dut (
        .sys_clk                       (sys_clk),
        .rst_n                         (rst_n),
        .meas_valid                    (meas_valid),
        .neg_seq_fundamental_magnitude (magnitude),
        .settings                      (settings),
        .start_out                     (start_out),
        .trip_out                      (trip_out)
    );

    upstream_phasor_model #(.PERIOD(40)) i_src (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .level_in   (level),
        .meas_valid (meas_valid),
        .magnitude  (magnitude)
    );

    // =================================================================
    // Helpers
    task automatic summarize();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_ms(input string name, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("ERROR %s expected %0d..%0d ms seen %0d ms", name, lo, hi, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Mode off first, which clears all timing, then the wanted settings
    task automatic setup(input logic [3:0] m, input logic [15:0] tms, input logic [15:0] dly,
                         input logic [15:0] mind, input logic [15:0] rdly);
        settings.mode = `MODE_OFF;
        level = 16'h0000;
        cycles(5);
        settings = '{m, 16'h0064, tms, dly, mind, rdly};
    endtask

    // Whole "ms" from start_out rising to trip_out rising
    task automatic time_trip(input logic [15:0] mag, output int got);
        int n;
        level = mag;
        n = 0;
        while (start_out !== 1'b1 && n < 200) begin
            cycles(1);
            n++;
        end
        n = 0;
        while (trip_out !== 1'b1 && n < 400 * TICK) begin
            cycles(1);
            n++;
        end
        got = n / TICK;
    endtask

    task automatic inv(input logic [3:0] m, input logic [15:0] tms, input logic [15:0] mag,
                       input logic [15:0] mind, input int lo, input int hi);
        setup(m, tms, 16'h0000, mind, 16'h0000);
        time_trip(mag, ms);
        check_ms("inverse trip time", lo, hi, ms);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_threshold();
        setup(`MODE_DEFINITE, 16'h0100, 16'h0014, 16'h0000, 16'h0000);
        level = 16'h0064;
        cycles(120);
        check_bit("start at setting", 1'b0, start_out);
        level = 16'h0065;
        cycles(120);
        check_bit("start above setting", 1'b1, start_out);
        level = 16'h0000;
        cycles(120);
        check_bit("start after drop", 1'b0, start_out);
    endtask

    task automatic t_mode_off();
        for (int m = 13; m <= 16; m++) begin
            setup(4'(m), 16'h0100, 16'h0001, 16'h0000, 16'h0000);
            level = 16'h0FA0;
            cycles(200);
            check_bit("start in off mode", 1'b0, start_out);
            check_bit("trip in off mode", 1'b0, trip_out);
        end
    endtask

    task automatic t_definite();
        logic [15:0] mags [2] = '{16'h00C8, 16'h0FA0};
        foreach (mags[i]) begin
            setup(`MODE_DEFINITE, 16'h0100, 16'h0014, 16'h0000, 16'h000A);
            time_trip(mags[i], ms);
            check_ms("definite trip time", 19, 20, ms);
            level = 16'h0000;
            cycles(45);
            check_bit("trip after drop", 1'b0, trip_out);
        end
    endtask

    task automatic t_inverse();
        inv(4'h2, 16'h0001, 16'h00C8, 16'h0000, 36, 43);
        inv(4'h3, 16'h0010, 16'h03E8, 16'h0000, 90, 97);
        inv(4'h4, 16'h0010, 16'h03E8, 16'h0000, 48, 53);
        inv(4'h4, 16'h0010, 16'h07D0, 16'h0000, 11, 14);
        inv(4'h4, 16'h0010, 16'h0FA0, 16'h0000, 11, 14);
        inv(4'h8, 16'h0010, 16'h0FA0, 16'h0000, 32, 36);
        inv(4'h4, 16'h0010, 16'h0FA0, 16'h001E, 29, 31);
        inv(4'h3, 16'h0001, 16'h0078, 16'h0000, 255, 273);
    endtask

    task automatic t_reset_delay();
        setup(`MODE_DEFINITE, 16'h0100, 16'h0014, 16'h0000, 16'h000A);
        level = 16'h00C8;
        cycles(10 * TICK);
        level = 16'h0000;
        cycles(3 * TICK);
        check_bit("trip during hold", 1'b0, trip_out);
        time_trip(16'h00C8, ms);
        check_ms("resumed delay", 8, 12, ms);
        level = 16'h0000;
        cycles(15 * TICK);
        time_trip(16'h00C8, ms);
        check_ms("delay after reset", 19, 20, ms);
    endtask

    // Short dip keeps the curve share, a dip past the reset time clears it
    task automatic t_ansi_reset();
        setup(4'h6, 16'h0010, 16'h0000, 16'h0000, 16'h0000);
        level = 16'h00C8;
        cycles(20 * TICK);
        level = 16'h0000;
        cycles(10 * TICK);
        check_bit("trip during ansi hold", 1'b0, trip_out);
        time_trip(16'h00C8, ms);
        check_ms("ansi resumed delay", 18, 24, ms);
        level = 16'h0000;
        cycles(45 * TICK);
        time_trip(16'h00C8, ms);
        check_ms("ansi delay after reset", 38, 43, ms);
    endtask

    // =================================================================
    // Clock, reset, sequence and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (80000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        level = 16'h0000;
        settings = '0;
        bad_count = 0;
        n_checks = 0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        check_bit("start after reset", 1'b0, start_out);
        t_threshold();
        t_mode_off();
        t_definite();
        t_inverse();
        t_reset_delay();
        t_ansi_reset();
        summarize();
    end
endmodule

// File: upstream_phasor_model.sv
/*
 * Stand-in for the upstream Fourier and sequence stage: one magnitude
 * sample with a one-cycle valid strobe every PERIOD clocks.
 * Assumes the bench sets the wanted level and that sys_clk is shared.
 */
module upstream_phasor_model #(
    parameter int unsigned PERIOD = 40
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] level_in,
    output logic             meas_valid,
    output logic [15:0]      magnitude
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned cnt;

    initial begin
        meas_valid = 1'b0;
        magnitude  = 16'h0000;
        cnt        = 0;
    end

    // =================================================================
    // Sample launch, off the sampling edge
    always @(negedge sys_clk) begin
        if (!rst_n || cnt != PERIOD - 1) begin
            meas_valid <= 1'b0;
            // Data is meaningless between strobes, so keep it moving
            magnitude  <= ~magnitude;
        end else begin
            meas_valid <= 1'b1;
            magnitude  <= level_in;
        end
        cnt <= (!rst_n || cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
endmodule
